// ===== src/crg_pkg.sv
// Shared constants and types for the register file and guard block.
package crg_pkg;
    localparam int GPR_NUM = 32;
    localparam int IDX_W = 5;
    localparam logic [4:0] PTR_BASE = 5'h1a;
    localparam logic [1:0] PTR_Z = 2'h2;
    localparam logic [7:0] IO_CCP = 8'h04;
    localparam logic [7:0] IO_TEMP = 8'h08;
    localparam logic [7:0] IO_SP_LO = 8'h0d;
    localparam logic [7:0] IO_SP_HI = 8'h0e;
    localparam logic [7:0] IO_FLAGS = 8'h0f;
    localparam logic [7:0] SIG_IO = 8'hd8;
    localparam logic [7:0] SIG_SPM = 8'h9d;
    localparam logic [2:0] WIN_INSTR = 3'h4;
    localparam int FLAG_IE = 7;
    localparam logic [15:0] SP_RESET = 16'hffff;
    // APB byte offsets of the controller registers.
    localparam logic [7:0] A_OPER = 8'h00;
    localparam logic [7:0] A_WDATA = 8'h04;
    localparam logic [7:0] A_PTR = 8'h08;
    localparam logic [7:0] A_IO = 8'h0c;
    localparam logic [7:0] A_EVT = 8'h10;
    localparam logic [7:0] A_GO = 8'h14;
    localparam logic [7:0] A_BP = 8'h18;
    localparam logic [7:0] A_DBGEN = 8'h1c;
    localparam logic [7:0] A_RES0 = 8'h20;
    localparam logic [7:0] A_RES1 = 8'h24;
    localparam int GO_REG = 0;
    localparam int GO_PTR = 1;
    localparam int GO_IO = 2;
    localparam int GO_EVT = 3;
    localparam int ST_PROT = 26;
    localparam int ST_NVM = 27;
    localparam int ST_IRQ = 28;
    localparam int ST_HALT = 29;
    localparam int ST_LATE = 30;
    typedef enum logic [1:0] {
        CRG_PTR_PLAIN,
        CRG_PTR_DISP,
        CRG_PTR_POSTINC,
        CRG_PTR_PREDEC
    } crg_ptr_mode_t;
    typedef struct packed {
        logic [15:0] value;
        logic [7:0] temp;
    } crg_wide_st_t;
    typedef struct packed {
        logic [GPR_NUM-1:0][7:0] gpr;
        logic [7:0] flags;
        logic io_unl;
        logic spm_unl;
        logic [2:0] cnt;
        logic [7:0] rd_a;
        logic [7:0] rd_b;
        logic [15:0] rd_w;
        logic [15:0] ptr_addr;
        logic [7:0] io_rdata;
        logic prot_wr_ok;
        logic nvm_ok;
        logic irq_take;
        logic dbg_halt;
    } crg_dev_st_t;
endpackage

// ===== src/crg_link_if.sv
// Link between the CPU decoder end and the register file end.
`timescale 1ns/10ps
interface crg_link_if;
    logic [4:0] rd_a_idx;
    logic [4:0] rd_b_idx;
    logic wr_en;
    logic wr_wide;
    logic [4:0] wr_idx;
    logic [15:0] wr_data;
    logic ptr_req;
    logic [1:0] ptr_sel;
    logic [1:0] ptr_mode;
    logic [5:0] ptr_disp;
    logic ptr_zonly;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_addr;
    logic [7:0] io_wdata;
    logic instr_done;
    logic dmem_write;
    logic nvm_access;
    logic sleep_exec;
    logic irq_req;
    logic [15:0] pc;
    logic pc_valid;
    logic cof;
    logic brk;
    logic [15:0] bp0;
    logic [15:0] bp1;
    logic [3:0] dbg_en;
    logic [7:0] rd_a;
    logic [7:0] rd_b;
    logic [15:0] rd_w;
    logic [15:0] ptr_addr;
    logic [7:0] io_rdata;
    logic io_unlock;
    logic spm_unlock;
    logic prot_wr_ok;
    logic nvm_ok;
    logic irq_take;
    logic dbg_halt;
    modport dev (
        input rd_a_idx, rd_b_idx, wr_en, wr_wide, wr_idx, wr_data, ptr_req, ptr_sel,
        input ptr_mode, ptr_disp, ptr_zonly, io_wr, io_rd, io_addr, io_wdata,
        input instr_done, dmem_write, nvm_access, sleep_exec, irq_req, pc, pc_valid,
        input cof, brk, bp0, bp1, dbg_en,
        output rd_a, rd_b, rd_w, ptr_addr, io_rdata, io_unlock, spm_unlock,
        output prot_wr_ok, nvm_ok, irq_take, dbg_halt
    );
    modport host (
        output rd_a_idx, rd_b_idx, wr_en, wr_wide, wr_idx, wr_data, ptr_req, ptr_sel,
        output ptr_mode, ptr_disp, ptr_zonly, io_wr, io_rd, io_addr, io_wdata,
        output instr_done, dmem_write, nvm_access, sleep_exec, irq_req, pc, pc_valid,
        output cof, brk, bp0, bp1, dbg_en,
        input rd_a, rd_b, rd_w, ptr_addr, io_rdata, io_unlock, spm_unlock,
        input prot_wr_ok, nvm_ok, irq_take, dbg_halt
    );
endinterface

// ===== src/crg_wide16.sv
// Sixteen-bit register reached byte-wise through a temporary byte.
`timescale 1ns/10ps
module crg_wide16 #(
    parameter logic [15:0] RESET_VAL = crg_pkg::SP_RESET
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Byte access strobes.
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic wr_tmp,
    input wire logic rd_lo,
    input wire logic [7:0] wdata,
    // Contents.
    output logic [15:0] value,
    output logic [7:0] temp
);
    import crg_pkg::*;
    crg_wide_st_t s;
    crg_wide_st_t n;
    always_comb begin
        n = s;
        if (wr_lo) begin
            n.temp = wdata;
        end
        if (wr_hi) begin
            n.value = {wdata, s.temp};
        end
        if (rd_lo) begin
            n.temp = s.value[15:8];
        end
        if (wr_tmp) begin
            n.temp = wdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{value: RESET_VAL, temp: 8'h00};
        end else begin
            s <= n;
        end
    end
    assign value = s.value;
    assign temp = s.temp;
endmodule // crg_wide16

// ===== src/crg_regfile_dev.sv
// Register file, pointer pairs, wide access and change guard of the CPU.
`timescale 1ns/10ps
module crg_regfile_dev (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Link to the CPU decoder.
    crg_link_if.dev link
);
    import crg_pkg::*;
    crg_dev_st_t s;
    crg_dev_st_t n;
    logic [15:0] sp_value;
    logic [7:0] sp_temp;
    logic sp_wr_lo;
    logic sp_wr_hi;
    logic tmp_wr;
    logic sp_rd_lo;
    logic [4:0] p_lo;
    logic [4:0] p_hi;
    logic [4:0] a_even;
    logic [4:0] w_hi;
    logic [15:0] p_val;
    logic [15:0] p_next;
    logic [1:0] p_sel;
    logic sig_wr;
    logic win_open;
    logic bp_hit;

    assign sp_wr_lo = link.io_wr && (link.io_addr == IO_SP_LO);
    assign sp_wr_hi = link.io_wr && (link.io_addr == IO_SP_HI);
    assign tmp_wr = link.io_wr && (link.io_addr == IO_TEMP);
    assign sp_rd_lo = link.io_rd && (link.io_addr == IO_SP_LO);

    crg_wide16 #(
        .RESET_VAL(SP_RESET)
    ) u_sp (
        .pclk(pclk),
        .presetn(presetn),
        .wr_lo(sp_wr_lo),
        .wr_hi(sp_wr_hi),
        .wr_tmp(tmp_wr),
        .rd_lo(sp_rd_lo),
        .wdata(link.io_wdata),
        .value(sp_value),
        .temp(sp_temp)
    );

    always_comb begin
        n = s;
        n.rd_a = s.gpr[link.rd_a_idx];
        n.rd_b = s.gpr[link.rd_b_idx];
        a_even = {link.rd_a_idx[4:1], 1'b0};
        n.rd_w = {s.gpr[a_even | 5'h01], s.gpr[a_even]};
        w_hi = link.wr_idx | 5'h01;
        if (link.wr_en && link.wr_wide) begin
            n.gpr[{link.wr_idx[4:1], 1'b0}] = link.wr_data[7:0];
            n.gpr[w_hi] = link.wr_data[15:8];
        end else if (link.wr_en) begin
            n.gpr[link.wr_idx] = link.wr_data[7:0];
        end
        // program load forced onto highest pair.
        p_sel = link.ptr_zonly ? PTR_Z : link.ptr_sel;
        p_lo = 5'(PTR_BASE + {2'h0, p_sel, 1'b0});
        p_hi = p_lo | 5'h01;
        p_val = {s.gpr[p_hi], s.gpr[p_lo]};
        p_next = p_val;
        unique case (crg_ptr_mode_t'(link.ptr_mode))
            CRG_PTR_PLAIN: begin
                n.ptr_addr = p_val;
            end
            CRG_PTR_DISP: begin
                n.ptr_addr = 16'(p_val + {10'h000, link.ptr_disp});
            end
            CRG_PTR_POSTINC: begin
                n.ptr_addr = p_val;
                p_next = 16'(p_val + 16'h0001);
            end
            CRG_PTR_PREDEC: begin
                p_next = 16'(p_val - 16'h0001);
                n.ptr_addr = p_next;
            end
        endcase
        if (!link.ptr_req) begin
            n.ptr_addr = s.ptr_addr;
        end else begin
            n.gpr[p_lo] = p_next[7:0];
            n.gpr[p_hi] = p_next[15:8];
        end
        // I/O map holds no working register.
        n.io_rdata = s.io_rdata;
        if (link.io_rd) begin
            unique case (link.io_addr)
                IO_CCP: n.io_rdata = {6'h00, s.spm_unl, s.io_unl};
                IO_SP_LO: n.io_rdata = sp_value[7:0];
                IO_SP_HI: n.io_rdata = sp_temp;
                IO_TEMP: n.io_rdata = sp_temp;
                IO_FLAGS: n.io_rdata = s.flags;
                default: n.io_rdata = 8'h00;
            endcase
        end
        if (link.io_wr && (link.io_addr == IO_FLAGS)) begin
            n.flags = link.io_wdata;
        end
        sig_wr = link.io_wr && (link.io_addr == IO_CCP);
        n.prot_wr_ok = link.io_wr && !sig_wr && s.io_unl;
        n.nvm_ok = link.nvm_access && s.spm_unl;
        if (link.instr_done && (s.io_unl || s.spm_unl)) begin
            n.cnt = 3'(s.cnt + 3'h1);
            if (n.cnt >= WIN_INSTR) begin
                n.io_unl = 1'b0;
                n.spm_unl = 1'b0;
            end
        end
        if ((link.io_wr && !sig_wr) || link.dmem_write || link.nvm_access
                || link.sleep_exec) begin
            n.io_unl = 1'b0;
        end
        if (link.nvm_access || link.sleep_exec) begin
            n.spm_unl = 1'b0;
        end
        if (sig_wr && (link.io_wdata == SIG_IO)) begin
            n.io_unl = 1'b1;
            n.spm_unl = 1'b0;
            n.cnt = 3'h0;
        end else if (sig_wr && (link.io_wdata == SIG_SPM)) begin
            n.spm_unl = 1'b1;
            n.io_unl = 1'b0;
            n.cnt = 3'h0;
        end
        win_open = s.io_unl || s.spm_unl;
        n.irq_take = link.irq_req && s.flags[FLAG_IE] && !win_open;
        bp_hit = (link.dbg_en[0] && (link.pc == link.bp0))
            || (link.dbg_en[1] && (link.pc == link.bp1))
            || (link.dbg_en[2] && link.cof)
            || link.brk;
        n.dbg_halt = (link.pc_valid && bp_hit) || (link.dbg_en[3] && n.irq_take);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign link.rd_a = s.rd_a;
    assign link.rd_b = s.rd_b;
    assign link.rd_w = s.rd_w;
    assign link.ptr_addr = s.ptr_addr;
    assign link.io_rdata = s.io_rdata;
    assign link.io_unlock = s.io_unl;
    assign link.spm_unlock = s.spm_unl;
    assign link.prot_wr_ok = s.prot_wr_ok;
    assign link.nvm_ok = s.nvm_ok;
    assign link.irq_take = s.irq_take;
    assign link.dbg_halt = s.dbg_halt;
endmodule // crg_regfile_dev

// ===== src/crg_cpu_host.sv
// CPU decoder end: APB command registers driving the register file link.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module crg_cpu_host #(
    parameter logic [7:0] LOCK_MASK = 8'h00
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to the register file.
    crg_link_if.host link
);
    import crg_pkg::*;
    typedef struct packed {
        logic [31:0] oper;
        logic [15:0] wdata;
        logic [12:0] ptr;
        logic [18:0] io;
        logic [31:0] evt;
        logic [31:0] bp;
        logic [3:0] dbgen;
        logic [4:0] sticky;
        logic arm;
        logic [2:0] cnt;
        logic wr_en;
        logic ptr_req;
        logic io_wr;
        logic io_rd;
        logic [7:0] io_wdata;
        logic [3:0] pulse;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } crg_host_st_t;
    crg_host_st_t s;
    crg_host_st_t n;
    logic wr_acc;
    logic [3:0] go;
    logic hit;
    logic prot_target;
    logic [31:0] rd_mux;

    always_comb begin
        n = s;
        wr_acc = psel && penable && s.pready && pwrite;
        go = (wr_acc && (paddr == A_GO)) ? pwdata[3:0] : 4'h0;
        hit = 1'b1;
        unique case (paddr)
            A_OPER: rd_mux = s.oper;
            A_WDATA: rd_mux = {16'h0000, s.wdata};
            A_PTR: rd_mux = {19'h00000, s.ptr};
            A_IO: rd_mux = {13'h0000, s.io};
            A_EVT: rd_mux = s.evt;
            A_GO: rd_mux = 32'h00000000;
            A_BP: rd_mux = s.bp;
            A_DBGEN: rd_mux = {28'h0000000, s.dbgen};
            A_RES0: rd_mux = {link.rd_w, link.rd_b, link.rd_a};
            A_RES1: rd_mux = {1'b0, s.sticky, link.spm_unlock, link.io_unlock,
                link.io_rdata, link.ptr_addr};
            default: begin
                rd_mux = 32'h00000000;
                hit = 1'b0;
            end
        endcase
        n.pready = psel && !penable && !s.pready;
        if (psel && !penable) begin
            n.prdata = rd_mux;
            n.pslverr = !hit;
        end
        if (wr_acc) begin
            unique case (paddr)
                A_OPER: n.oper = pwdata;
                A_WDATA: n.wdata = pwdata[15:0];
                A_PTR: n.ptr = pwdata[12:0];
                A_IO: n.io = pwdata[18:0];
                A_EVT: n.evt = pwdata;
                A_BP: n.bp = pwdata;
                A_DBGEN: n.dbgen = pwdata[3:0];
                A_RES1: n.sticky = s.sticky & ~pwdata[ST_LATE:ST_PROT];
                default: n.pslverr = s.pslverr;
            endcase
        end
        n.wr_en = go[GO_REG] && s.oper[24];
        n.ptr_req = go[GO_PTR];
        // byte accesses issued in software order.
        n.io_wr = go[GO_IO] && s.io[16];
        n.io_rd = go[GO_IO] && s.io[17];
        prot_target = s.arm && link.io_unlock && (s.io[7:0] != IO_CCP);
        n.io_wdata = prot_target ? (s.io[15:8] | LOCK_MASK) : s.io[15:8];
        n.pulse = go[GO_EVT] ? s.evt[3:0] : 4'h0;
        if (n.pulse[0] && s.arm && (s.cnt != WIN_INSTR)) begin
            n.cnt = 3'(s.cnt + 3'h1);
        end
        if ((n.io_wr && prot_target) || (n.pulse[2] && s.arm)) begin
            n.arm = 1'b0;
            if (s.cnt >= WIN_INSTR) begin
                n.sticky[ST_LATE-ST_PROT] = 1'b1;
            end
        end
        if (n.io_wr && (s.io[7:0] == IO_CCP)
                && ((s.io[15:8] == SIG_IO) || (s.io[15:8] == SIG_SPM))) begin
            n.arm = 1'b1;
            n.cnt = 3'h0;
        end
        if (link.prot_wr_ok) begin
            n.sticky[ST_PROT-ST_PROT] = 1'b1;
        end
        if (link.nvm_ok) begin
            n.sticky[ST_NVM-ST_PROT] = 1'b1;
        end
        if (link.irq_take) begin
            n.sticky[ST_IRQ-ST_PROT] = 1'b1;
        end
        if (link.dbg_halt) begin
            n.sticky[ST_HALT-ST_PROT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign link.rd_a_idx = s.oper[4:0];
    assign link.rd_b_idx = s.oper[12:8];
    assign link.wr_idx = s.oper[20:16];
    assign link.wr_wide = s.oper[25];
    assign link.wr_en = s.wr_en;
    assign link.wr_data = s.wdata;
    assign link.ptr_req = s.ptr_req;
    assign link.ptr_sel = s.ptr[1:0];
    assign link.ptr_mode = s.ptr[3:2];
    assign link.ptr_disp = s.ptr[9:4];
    assign link.ptr_zonly = s.ptr[12];
    assign link.io_wr = s.io_wr;
    assign link.io_rd = s.io_rd;
    assign link.io_addr = s.io[7:0];
    assign link.io_wdata = s.io_wdata;
    assign link.instr_done = s.pulse[0];
    assign link.dmem_write = s.pulse[1];
    assign link.nvm_access = s.pulse[2];
    assign link.sleep_exec = s.pulse[3];
    assign link.irq_req = s.evt[4] && !s.io[18];
    assign link.pc_valid = s.evt[5];
    assign link.cof = s.evt[6];
    assign link.brk = s.evt[7];
    assign link.pc = s.evt[31:16];
    assign link.bp0 = s.bp[15:0];
    assign link.bp1 = s.bp[31:16];
    assign link.dbg_en = s.dbgen;
endmodule // crg_cpu_host

// ===== verification/crg_link_assertions.sv
// Concurrent checks on the link between the decoder end and the register file end.
`timescale 1ns/10ps
module crg_link_assertions
    import crg_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Decoder side.
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic instr_done,
    input wire logic dmem_write,
    input wire logic nvm_access,
    input wire logic sleep_exec,
    // Register file side.
    input wire logic [7:0] io_rdata,
    input wire logic io_unlock,
    input wire logic spm_unlock,
    input wire logic prot_wr_ok,
    input wire logic nvm_ok,
    input wire logic irq_take
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic guard_wr;
    logic sig_wr;
    logic [2:0] n_ins;
    assign guard_wr = io_wr && io_addr == IO_CCP;
    assign sig_wr = guard_wr && (io_wdata == SIG_IO || io_wdata == SIG_SPM);
    // Counts instructions retired inside an open window.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_ins <= 3'h0;
        end else if (sig_wr) begin
            n_ins <= 3'h0;
        end else if (instr_done && (io_unlock || spm_unlock)) begin
            n_ins <= n_ins + 3'h1;
        end
    end
    sequence s_sig_io;
        guard_wr && io_wdata == SIG_IO;
    endsequence
    sequence s_sig_spm;
        guard_wr && io_wdata == SIG_SPM;
    endsequence
    property p_io_open;
        s_sig_io |=> io_unlock;
    endproperty
    property p_spm_open;
        s_sig_spm |=> spm_unlock;
    endproperty
    property p_irq_held;
        io_unlock || spm_unlock |=> !irq_take;
    endproperty
    property p_io_close;
        io_unlock && !sig_wr && (dmem_write || nvm_access || sleep_exec || (io_wr && !guard_wr))
            |=> !io_unlock;
    endproperty
    property p_spm_close;
        spm_unlock && !sig_wr && (nvm_access || sleep_exec) |=> !spm_unlock;
    endproperty
    property p_expire;
        (io_unlock || spm_unlock) && instr_done && n_ins == 3'h3 && !sig_wr
            |=> !io_unlock && !spm_unlock;
    endproperty
    property p_prot_ok;
        io_wr && !guard_wr |=> prot_wr_ok == $past(io_unlock);
    endproperty
    property p_nvm_ok;
        nvm_access |=> nvm_ok == $past(spm_unlock);
    endproperty
    property p_guard_rd;
        io_rd && io_addr == IO_CCP |=> io_rdata == {6'h00, $past(spm_unlock), $past(io_unlock)};
    endproperty
    a_io_open: assert property (p_io_open) else $error("io window did not open");
    a_spm_open: assert property (p_spm_open) else $error("spm window did not open");
    a_irq_held: assert property (p_irq_held) else $error("irq taken in window");
    a_io_close: assert property (p_io_close) else $error("io window stayed open");
    a_spm_close: assert property (p_spm_close) else $error("spm window stayed open");
    a_expire: assert property (p_expire) else $error("window outlived four instr");
    a_prot_ok: assert property (p_prot_ok) else $error("protected write gate wrong");
    a_nvm_ok: assert property (p_nvm_ok) else $error("nvm gate wrong");
    a_guard_rd: assert property (p_guard_rd) else $error("guard readback wrong");
endmodule // crg_link_assertions

// ===== verification/cpu_regfile_wide_access_guard_bench.sv
// Self-checking bench joining both ends through the link interface.
`timescale 1ns/10ps
module cpu_regfile_wide_access_guard_bench;
    import crg_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int n_mismatch, checks, cyc;
    crg_link_if link ();
    crg_regfile_dev crg_regfile_dev_i (.pclk(pclk), .presetn(presetn), .link(link));
    crg_cpu_host crg_cpu_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    crg_link_assertions crg_link_assertions_i (.pclk(pclk), .presetn(presetn),
        .io_wr(link.io_wr), .io_rd(link.io_rd), .io_addr(link.io_addr),
        .io_wdata(link.io_wdata), .instr_done(link.instr_done), .dmem_write(link.dmem_write),
        .nvm_access(link.nvm_access), .sleep_exec(link.sleep_exec), .io_rdata(link.io_rdata),
        .io_unlock(link.io_unlock), .spm_unlock(link.spm_unlock),
        .prot_wr_ok(link.prot_wr_ok), .nvm_ok(link.nvm_ok), .irq_take(link.irq_take));
    task automatic test_done;
        if (n_mismatch == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic go(input logic [31:0] b);
        apb(1'b1, A_GO, b);
        repeat (3) @(posedge pclk);
    endtask
    task automatic io(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
        apb(1'b1, A_IO, {14'h0, r, w, d, a});
        go(32'h4);
    endtask
    task automatic evt(input logic [7:0] b);
        apb(1'b1, A_EVT, {24'h0, b});
        go(32'h8);
    endtask
    task automatic res1;
        apb(1'b0, A_RES1, 32'h0);
    endtask
    task automatic iord(input logic [7:0] a, input logic [7:0] exp);
        io(a, 8'h00, 1'b0, 1'b1);
        res1();
        chk(rd[23:16], exp);
    endtask
    task automatic ptr(input logic [31:0] v, input logic [15:0] exp);
        apb(1'b1, A_PTR, v);
        go(32'h2);
        res1();
        chk(rd[15:0], exp);
    endtask
    task automatic dbg(input logic [3:0] en, input logic [31:0] e, input logic exp);
        apb(1'b1, A_DBGEN, {28'h0, en});
        apb(1'b1, A_EVT, e);
        apb(1'b1, A_RES1, 32'h7c00_0000);
        res1();
        chk(rd[29], exp);
    endtask
    task automatic t_dbg;
        apb(1'b1, A_BP, 32'h0200_0100);
        dbg(4'h1, 32'h0100_0020, 1'b1);
        dbg(4'h1, 32'h0100_0000, 1'b0);
        dbg(4'h1, 32'h0200_0020, 1'b0);
        dbg(4'h2, 32'h0200_0020, 1'b1);
        dbg(4'h3, 32'h0300_0060, 1'b0);
        dbg(4'h4, 32'h0300_0060, 1'b1);
        dbg(4'h0, 32'h0300_00a0, 1'b1);
        dbg(4'h0, 32'h0300_0010, 1'b0);
        dbg(4'h8, 32'h0300_0010, 1'b1);
    endtask
    task automatic t_gpr;
        apb(1'b1, A_WDATA, 32'h5a);
        apb(1'b1, A_OPER, 32'h0105_0505);
        go(32'h1);
        apb(1'b0, A_RES0, 32'h0);
        chk(rd[15:0], 16'h5a5a);
        apb(1'b1, A_WDATA, 32'h1234);
        apb(1'b1, A_OPER, 32'h031a_1b1a);
        go(32'h1);
        apb(1'b0, A_RES0, 32'h0);
        chk(rd, 32'h1234_1234);
        io(8'h05, 8'hff, 1'b1, 1'b0);
        apb(1'b1, A_OPER, 32'h0000_0505);
        apb(1'b0, A_RES0, 32'h0);
        chk(rd[15:0], 16'h5a5a);
    endtask
    task automatic t_ptr;
        ptr(32'h0, 16'h1234);
        ptr(32'h54, 16'h1239);
        ptr(32'h8, 16'h1234);
        ptr(32'h0, 16'h1235);
        ptr(32'hc, 16'h1234);
        apb(1'b1, A_WDATA, 32'hbeef);
        apb(1'b1, A_OPER, 32'h031e_1f1e);
        go(32'h1);
        ptr(32'h1001, 16'hbeef);
    endtask
    task automatic t_wide;
        iord(IO_SP_LO, SP_RESET[7:0]);
        iord(IO_SP_HI, SP_RESET[15:8]);
        io(IO_SP_LO, 8'h34, 1'b1, 1'b0);
        io(IO_SP_HI, 8'h12, 1'b1, 1'b0);
        iord(IO_SP_LO, 8'h34);
        iord(IO_SP_HI, 8'h12);
        io(IO_TEMP, 8'h77, 1'b1, 1'b0);
        iord(IO_TEMP, 8'h77);
        io(IO_SP_HI, 8'h56, 1'b1, 1'b0);
        iord(IO_SP_LO, 8'h77);
    endtask
    task automatic t_guard;
        apb(1'b1, A_RES1, 32'h7c00_0000);
        io(IO_FLAGS, 8'h80, 1'b1, 1'b0);
        res1();
        chk(rd[26], 1'b0);
        io(IO_CCP, 8'hd9, 1'b1, 1'b0);
        res1();
        chk(rd[25:24], 2'b00);
        io(IO_CCP, SIG_IO, 1'b1, 1'b0);
        iord(IO_CCP, 8'h01);
        io(IO_FLAGS, 8'h80, 1'b1, 1'b0);
        res1();
        chk({rd[30], rd[26], rd[24]}, 3'b010);
        io(IO_CCP, SIG_IO, 1'b1, 1'b0);
        evt(8'h02);
        res1();
        chk(rd[24], 1'b0);
        io(IO_CCP, SIG_IO, 1'b1, 1'b0);
        repeat (3) evt(8'h01);
        res1();
        chk(rd[24], 1'b1);
        evt(8'h01);
        res1();
        chk(rd[24], 1'b0);
    endtask
    task automatic t_spm;
        apb(1'b1, A_RES1, 32'h7c00_0000);
        evt(8'h04);
        res1();
        chk({rd[30], rd[27]}, 2'b10);
        io(IO_CCP, SIG_SPM, 1'b1, 1'b0);
        iord(IO_CCP, 8'h02);
        evt(8'h04);
        res1();
        chk(rd[27:25], 3'b100);
        io(IO_CCP, SIG_SPM, 1'b1, 1'b0);
        evt(8'h08);
        res1();
        chk(rd[25], 1'b0);
    endtask
    task automatic t_irq;
        apb(1'b1, A_RES1, 32'h7c00_0000);
        io(IO_CCP, SIG_IO, 1'b1, 1'b0);
        evt(8'h10);
        res1();
        chk(rd[28], 1'b0);
        repeat (4) evt(8'h11);
        res1();
        chk(rd[28], 1'b1);
        apb(1'b1, A_IO, 32'h0004_0000);
        apb(1'b1, A_RES1, 32'h7c00_0000);
        res1();
        chk(rd[28], 1'b0);
        apb(1'b1, A_IO, 32'h0);
        evt(8'h00);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_gpr();
        t_ptr();
        t_wide();
        t_guard();
        t_spm();
        t_irq();
        t_dbg();
        test_done();
    end
endmodule // cpu_regfile_wide_access_guard_bench
